// file: design/capture_pwm_timer.sv
// 16-bit timer with interval toggle, input capture and pwm modes
`timescale 1ns/1ps
`default_nettype none
module capture_pwm_timer (
  input  wire logic       clk_in,             // system clock, 250 MHz
  input  wire logic       srst_in,            // sync reset, high
  input  wire logic [7:0] reg_addr_in,        // register byte address
  input  wire logic       reg_wr_in,          // register write strobe
  input  wire logic [7:0] reg_wdata_in,       // register write data
  output logic      [7:0] reg_rdata_out,      // read data, one cycle late
  input  wire logic       pend_wr_in,         // pending register write
  input  wire logic [7:0] pend_wdata_in,      // pending write data
  input  wire logic       ovf_serviced_in,    // overflow vector serviced
  input  wire logic       mc_serviced_in,     // match vector serviced
  input  wire logic       mask_bit3_in,       // mask register bit 3
  input  wire logic       external_clock_pin_in, // external count clock
  input  wire logic       capture_input_pin_in,  // capture input
  output logic            toggle_output_pin_out, // toggle / pwm output
  output logic            ovf_pending_out,    // pending bit 4
  output logic            mc_pending_out,     // pending bit 5
  output logic            irq_out,            // shared interrupt level
  output logic      [7:0] vector_out          // vector of active request
);
  import timer_pkg::*;

  ctrl_t       ctrl_reg;      // control register
  logic [15:0] cnt_reg;       // up counter
  logic [15:0] ref_reg;       // reference / capture data
  logic        cap_prev_reg;  // last capture pin level
  logic        out_reg;       // output pin flop
  logic        ovf_pend_reg;  // overflow pending
  logic        mc_pend_reg;   // match/capture pending
  logic [7:0]  rdata_reg;     // registered read data
  logic        tick;          // counting clock enable
  logic        match;         // comparator hit
  logic        cap_edge;      // selected capture edge seen
  logic        is_capture;    // either capture mode
  logic        match_evt;     // interval match on a tick
  logic        ovf_evt;       // counter wrap on a tick
  logic        mc_evt;        // match or capture event
  logic        ctrl_wr;       // control register written

  count_prescaler #(
    .DIV_BITS (PRESCALE_BITS)
  ) u_prescaler (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .sel_in     (ctrl_reg.clk_sel),
    .ext_clk_in (external_clock_pin_in),
    .tick_out   (tick)
  );

  // event decode
  assign ctrl_wr    = reg_wr_in && (reg_addr_in == CTRL_ADDR);
  assign match      = (cnt_reg == ref_reg);
  assign is_capture = (ctrl_reg.mode == MODE_CAP_RISE) ||
                      (ctrl_reg.mode == MODE_CAP_FALL);
  assign cap_edge   = ((ctrl_reg.mode == MODE_CAP_RISE) &&
                       !cap_prev_reg && capture_input_pin_in) ||
                      ((ctrl_reg.mode == MODE_CAP_FALL) &&
                       cap_prev_reg && !capture_input_pin_in);
  assign match_evt  = tick && !ctrl_reg.clr &&
                      (ctrl_reg.mode == MODE_INTERVAL) && match;
  // overflow only when the counter truly wraps, not on an interval clear
  assign ovf_evt    = tick && !ctrl_reg.clr && !match_evt &&
                      (cnt_reg == CNT_MAX);
  assign mc_evt     = match_evt || cap_edge;

  // control register; clear bit self-returns after one cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_reg <= ctrl_t'(CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_t'(reg_wdata_in);
    end else if (ctrl_reg.clr) begin
      ctrl_reg.clr <= 1'b0;
    end
  end

  // counter: clear bit dominates, then interval match, else count up
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg <= CNT_ZERO;
    end else if (ctrl_reg.clr) begin
      cnt_reg <= CNT_ZERO;
    end else if (match_evt) begin
      cnt_reg <= CNT_ZERO;
    end else if (tick) begin
      // pwm and capture wrap naturally, 65536 ticks a lap
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // reference register: byte writes, capture load wins a collision
  // hazard: a byte write racing a capture is dropped so that the
  // captured word is never torn between old and new halves
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ref_reg <= CNT_ZERO;
    end else if (is_capture && cap_edge) begin
      ref_reg <= cnt_reg;
    end else if (reg_wr_in && reg_addr_in == REF_H_ADDR) begin
      ref_reg[15:8] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == REF_L_ADDR) begin
      ref_reg[7:0] <= reg_wdata_in;
    end
  end

  // capture pin history
  // reset level matches the idle pin so no false edge follows reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cap_prev_reg <= 1'b0;
    end else begin
      cap_prev_reg <= capture_input_pin_in;
    end
  end

  // single output pin shared by interval toggle and pwm
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      out_reg <= 1'b0;
    end else if (ctrl_reg.mode == MODE_PWM) begin
      out_reg <= (ref_reg > cnt_reg);
    end else if (match_evt) begin
      out_reg <= ~out_reg;
    end
  end

  // overflow pending: set wins over service or software clear
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ovf_pend_reg <= 1'b0;
    end else if (ovf_evt) begin
      ovf_pend_reg <= 1'b1;
    end else if (ovf_serviced_in ||
                 (pend_wr_in && !pend_wdata_in[OVF_PEND_BIT])) begin
      ovf_pend_reg <= 1'b0;
    end
  end

  // match/capture pending: hardware clear only when mask bit 3 set
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mc_pend_reg <= 1'b0;
    end else if (mc_evt) begin
      mc_pend_reg <= 1'b1;
    end else if (mc_serviced_in && mask_bit3_in && ctrl_reg.mc_en) begin
      mc_pend_reg <= 1'b0;
    end else if (pend_wr_in && !pend_wdata_in[MC_PEND_BIT]) begin
      mc_pend_reg <= 1'b0;
    end
  end

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (reg_addr_in)
        CTRL_ADDR:  rdata_reg <= ctrl_reg;
        CNT_H_ADDR: rdata_reg <= cnt_reg[15:8];
        CNT_L_ADDR: rdata_reg <= cnt_reg[7:0];
        REF_H_ADDR: rdata_reg <= ref_reg[15:8];
        REF_L_ADDR: rdata_reg <= ref_reg[7:0];
        default:    rdata_reg <= 8'h00;
      endcase
    end
  end

  // one shared level, overflow vector preferred when both request
  // limitation: only the winner is named; the other waits its turn
  always_comb begin
    irq_out    = (ovf_pend_reg && ctrl_reg.ovf_en) ||
                 (mc_pend_reg && ctrl_reg.mc_en);
    vector_out = (ovf_pend_reg && ctrl_reg.ovf_en) ? OVF_VECTOR
                                                   : MC_VECTOR;
  end

  // data outputs straight from flops so the pins never glitch
  assign reg_rdata_out         = rdata_reg;
  assign toggle_output_pin_out = out_reg;
  assign ovf_pending_out       = ovf_pend_reg;
  assign mc_pending_out        = mc_pend_reg;

  // checks next to the logic they guard
  a_reset_ctrl_zero: assert property (@(posedge clk_in)
    srst_in |=> (ctrl_reg == ctrl_t'(CTRL_RESET)))
    else $error("control not zero after reset");

  a_clear_bit_returns: assert property (@(posedge clk_in)
    disable iff (srst_in) ctrl_reg.clr && !ctrl_wr |=> !ctrl_reg.clr)
    else $error("clear bit did not return to zero");

  a_clear_zeroes_counter: assert property (@(posedge clk_in)
    disable iff (srst_in) ctrl_reg.clr |=> (cnt_reg == CNT_ZERO))
    else $error("clear bit did not zero counter");

  a_stop_holds_count: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (ctrl_reg.clk_sel == CLK_STOP) && !ctrl_reg.clr |=> $stable(cnt_reg))
    else $error("counter moved while stopped");

  a_interval_match_clear: assert property (@(posedge clk_in)
    disable iff (srst_in)
    match_evt |=> (cnt_reg == CNT_ZERO) && mc_pend_reg)
    else $error("interval match did not clear and flag");

  a_interval_toggle: assert property (@(posedge clk_in)
    disable iff (srst_in)
    match_evt |=> (out_reg != $past(out_reg)))
    else $error("output did not invert on match");

  a_pwm_level: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (ctrl_reg.mode == MODE_PWM) |=> (out_reg == ($past(ref_reg) >
                                                $past(cnt_reg))))
    else $error("pwm level wrong");

  a_capture_load: assert property (@(posedge clk_in)
    disable iff (srst_in)
    is_capture && cap_edge |=> (ref_reg == $past(cnt_reg)) && mc_pend_reg)
    else $error("capture did not load counter");

  a_overflow_flag: assert property (@(posedge clk_in)
    disable iff (srst_in) ovf_evt |=> ovf_pend_reg && (cnt_reg == CNT_ZERO))
    else $error("overflow not flagged on wrap");

  a_mc_hw_clear: assert property (@(posedge clk_in)
    disable iff (srst_in)
    mc_serviced_in && mask_bit3_in && ctrl_reg.mc_en && !mc_evt
    |=> !mc_pend_reg)
    else $error("serviced match flag not cleared");

  a_shared_vector: assert property (@(posedge clk_in)
    disable iff (srst_in)
    ovf_pend_reg && ctrl_reg.ovf_en |-> irq_out && (vector_out == OVF_VECTOR))
    else $error("overflow request not on shared level");

  // writes land whole, clear bit included, on the following edge
  a_ctrl_write: assert property (@(posedge clk_in)
    disable iff (srst_in)
    ctrl_wr |=> ({ctrl_reg} == $past(reg_wdata_in)))
    else $error("control write not taken");

  // pwm never clears on match: every tick steps, ffff wraps to zero
  a_pwm_free_run: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (ctrl_reg.mode == MODE_PWM) && tick && !ctrl_reg.clr
    |=> (cnt_reg == $past(cnt_reg) + 16'h0001))
    else $error("pwm counter did not step or wrap");

  // external codes count exactly the chosen pin edge
  a_ext_rise_tick: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (ctrl_reg.clk_sel == CLK_EXT_RISE) && $rose(external_clock_pin_in)
    |-> tick)
    else $error("rising external edge did not count");

  a_ext_fall_tick: assert property (@(posedge clk_in)
    disable iff (srst_in)
    (ctrl_reg.clk_sel == CLK_EXT_FALL) && $fell(external_clock_pin_in)
    |-> tick)
    else $error("falling external edge did not count");

  // pending flags: clears work unless a new event lands that cycle; the match service clear also needs mask bit 3
  a_ovf_service_clear: assert property (@(posedge clk_in)
    disable iff (srst_in)
    ovf_serviced_in && !ovf_evt |=> !ovf_pend_reg)
    else $error("serviced overflow flag not cleared");

  a_ovf_sw_clear: assert property (@(posedge clk_in)
    disable iff (srst_in)
    pend_wr_in && !pend_wdata_in[OVF_PEND_BIT] && !ovf_evt |=> !ovf_pend_reg)
    else $error("software overflow clear ignored");

  a_mc_sw_clear: assert property (@(posedge clk_in)
    disable iff (srst_in)
    pend_wr_in && !pend_wdata_in[MC_PEND_BIT] && !mc_evt |=> !mc_pend_reg)
    else $error("software match clear ignored");

  a_mc_kept_unmasked: assert property (@(posedge clk_in)
    disable iff (srst_in)
    mc_pend_reg && !mask_bit3_in && !pend_wr_in |=> mc_pend_reg)
    else $error("match flag lost without software clear");

  // flags only rise for their own cause
  a_ovf_cause: assert property (@(posedge clk_in)
    disable iff (srst_in)
    $rose(ovf_pend_reg) |-> ($past(cnt_reg) == CNT_MAX))
    else $error("overflow flag without a wrap");

  a_mc_cause: assert property (@(posedge clk_in)
    disable iff (srst_in)
    $rose(mc_pend_reg) |-> $past(match_evt) || $past(cap_edge))
    else $error("match flag without match or capture");

  c_interval_match: cover property (@(posedge clk_in)
    disable iff (srst_in) match_evt);
  c_capture_load: cover property (@(posedge clk_in)
    disable iff (srst_in) is_capture && cap_edge);
  c_pwm_wrap: cover property (@(posedge clk_in)
    disable iff (srst_in) (ctrl_reg.mode == MODE_PWM) && ovf_evt);
  c_ovf_serviced: cover property (@(posedge clk_in)
    disable iff (srst_in) ovf_serviced_in && ovf_pend_reg);
  c_mc_hw_clear: cover property (@(posedge clk_in)
    disable iff (srst_in) mc_serviced_in && mask_bit3_in && mc_pend_reg);

endmodule
`default_nettype wire

// file: common/timer_pkg.sv
// constants, field layouts and carrier types for the 16-bit capture/pwm timer
package timer_pkg;

  // register offsets on the byte register port
  localparam logic [7:0] CTRL_ADDR  = 8'h0a;
  localparam logic [7:0] CNT_H_ADDR = 8'h0c;
  localparam logic [7:0] CNT_L_ADDR = 8'h0d;
  localparam logic [7:0] REF_H_ADDR = 8'h0e;
  localparam logic [7:0] REF_L_ADDR = 8'h0f;

  // reset value of the control register
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // pending register bit positions
  localparam int OVF_PEND_BIT = 4;
  localparam int MC_PEND_BIT  = 5;

  // interrupt vectors on the shared level
  localparam logic [7:0] OVF_VECTOR = 8'hde;
  localparam logic [7:0] MC_VECTOR  = 8'hdc;

  // counter limits
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // prescaler width (largest division is 1024)
  localparam int PRESCALE_BITS = 10;

  // clock-select codes
  typedef enum logic [2:0] {
    CLK_DIV1024,
    CLK_DIV256,
    CLK_DIV64,
    CLK_DIV8,
    CLK_DIV1,
    CLK_EXT_FALL,
    CLK_EXT_RISE,
    CLK_STOP
  } clk_sel_t;

  // operating modes
  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_CAP_RISE,
    MODE_CAP_FALL,
    MODE_PWM
  } mode_t;

  // control register layout, msb first
  typedef struct packed {
    clk_sel_t clk_sel;  // bits 7:5
    mode_t    mode;     // bits 4:3
    logic     clr;      // bit 2
    logic     mc_en;    // bit 1
    logic     ovf_en;   // bit 0
  } ctrl_t;

endpackage

// file: design/count_prescaler.sv
// prescaler producing the counting tick from system clock or external pin
`timescale 1ns/1ps
`default_nettype none
module count_prescaler #(
  parameter int DIV_BITS = timer_pkg::PRESCALE_BITS  // divider width
) (
  input  wire logic              clk_in,       // system clock
  input  wire logic              srst_in,      // sync reset, high
  input  wire timer_pkg::clk_sel_t sel_in,     // clock select code
  input  wire logic              ext_clk_in,   // external clock pin level
  output logic                   tick_out      // one-cycle count enable
);
  import timer_pkg::*;

  logic [DIV_BITS-1:0] div_reg;   // free-running divider
  logic                ext_prev_reg; // last external pin level

  // divider runs always so any code change picks a running phase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // external pin history for edge detection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_in;
    end
  end

  // tick select; each division ticks when its low bits are all ones
  always_comb begin
    unique case (sel_in)
      CLK_DIV1024:  tick_out = &div_reg[9:0];
      CLK_DIV256:   tick_out = &div_reg[7:0];
      CLK_DIV64:    tick_out = &div_reg[5:0];
      CLK_DIV8:     tick_out = &div_reg[2:0];
      CLK_DIV1:     tick_out = 1'b1;
      CLK_EXT_FALL: tick_out = ext_prev_reg & ~ext_clk_in;
      CLK_EXT_RISE: tick_out = ~ext_prev_reg & ext_clk_in;
      CLK_STOP:     tick_out = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// file: sim/pin_model.sv
// far-side pin model: external count clock and capture pin
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input  wire logic clk_in,  // system clock
  input  wire logic run_in,  // let the external clock run
  input  wire logic cap_in,  // wanted capture pin level
  output logic      ext_out, // external clock pin
  output logic      cap_out  // capture pin
);
  initial begin
    ext_out = 1'b0;
    cap_out = 1'b0;
  end
  // pins move after the falling edge, away from the sampling edge;
  // the clock stands still between bursts instead of running free
  always @(negedge clk_in) begin
    if (run_in) begin
      ext_out <= ~ext_out;
    end
    cap_out <= cap_in; // port field assumed to select capture
  end
endmodule
`default_nettype wire

// file: sim/capture_pwm_timer_tb.sv
// self-checking bench for the 16-bit capture/pwm timer
`timescale 1ns/1ps
`default_nettype none
module capture_pwm_timer_tb;
  import timer_pkg::*;
  logic       clk_in = 1'b0;      // system clock
  logic       srst_in = 1'b1;     // sync reset
  logic [7:0] reg_addr_in = 8'h00; // register address
  logic       reg_wr_in = 1'b0;   // write strobe
  logic [7:0] reg_wdata_in = 8'h00; // write data
  logic [7:0] reg_rdata_out;      // read data
  logic       pend_wr_in = 1'b0;  // pending write
  logic [7:0] pend_wdata_in = 8'hff; // pending data
  logic       ovf_srv = 1'b0;     // overflow serviced
  logic       mc_srv = 1'b0;      // match serviced
  logic       mask3 = 1'b0;       // mask bit 3
  logic       ext_run = 1'b0;     // external clock burst
  logic       cap_lvl = 1'b0;     // capture level wanted
  logic       ext_pin;            // external clock pin
  logic       cap_pin;            // capture pin
  logic       out_pin;            // toggle / pwm pin
  logic       ovf_p;              // overflow pending
  logic       mc_p;               // match pending
  logic       irq;                // shared request
  logic [7:0] vec;                // vector
  int         num_errors = 0;     // mismatches
  int         checks_done = 0;    // comparisons
  logic [7:0] d0;                 // read scratch
  logic [7:0] d1;                 // read scratch

  // 250 MHz system clock
  always #2 clk_in = ~clk_in;

  capture_pwm_timer u_dut (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .pend_wr_in(pend_wr_in), .pend_wdata_in(pend_wdata_in),
    .ovf_serviced_in(ovf_srv), .mc_serviced_in(mc_srv),
    .mask_bit3_in(mask3), .external_clock_pin_in(ext_pin),
    .capture_input_pin_in(cap_pin), .toggle_output_pin_out(out_pin),
    .ovf_pending_out(ovf_p), .mc_pending_out(mc_p), .irq_out(irq),
    .vector_out(vec));

  pin_model u_pins (.clk_in(clk_in), .run_in(ext_run), .cap_in(cap_lvl),
    .ext_out(ext_pin), .cap_out(cap_pin));

  // one comparison, counted; unknowns never match
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  // read data lands one cycle after the address edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask

  task automatic pend(input logic [7:0] d);
    @(negedge clk_in);
    pend_wdata_in = d;
    pend_wr_in = 1'b1;
    @(negedge clk_in);
    pend_wr_in = 1'b0;
  endtask

  task automatic serv(input logic ovf);
    @(negedge clk_in);
    if (ovf) ovf_srv = 1'b1;
    else mc_srv = 1'b1;
    @(negedge clk_in);
    ovf_srv = 1'b0;
    mc_srv = 1'b0;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_reset();
    rd(CTRL_ADDR, d0);
    chk("ctrl reset", 16'h0000, {8'h00, d0});
    chk("irq reset", 16'h0000, {15'h0, irq});
    rd(8'h20, d0);
    chk("unmapped", 16'h0000, {8'h00, d0});
  endtask

  // counter advance over two prescaler periods, every divider code
  task automatic t_divide();
    int dv[5] = '{1024, 256, 64, 8, 1};
    wr(REF_H_ADDR, 8'hff);
    wr(REF_L_ADDR, 8'hff);
    for (int c = 0; c < 5; c++) begin
      wr(CTRL_ADDR, {c[2:0], 5'h00});
      rd(CNT_L_ADDR, d0);
      repeat (2 * dv[c] - 2) @(negedge clk_in);
      rd(CNT_L_ADDR, d1);
      chk("div delta", 16'h0002, {8'h00, d1 - d0});
    end
  endtask

  // five external pulses give five counts on either edge code
  task automatic t_ext();
    for (int c = 5; c < 7; c++) begin
      wr(CTRL_ADDR, {c[2:0], 5'h00});
      rd(CNT_L_ADDR, d0);
      ext_run <= 1'b1;
      repeat (10) @(negedge clk_in);
      ext_run <= 1'b0;
      repeat (3) @(negedge clk_in);
      rd(CNT_L_ADDR, d1);
      chk("ext delta", 16'h0005, {8'h00, d1 - d0});
    end
  endtask

  // cycles until the output pin flips, bounded
  task automatic wait_flip(output int n);
    logic t0;
    t0 = out_pin;
    n = 0;
    while (out_pin === t0 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 40) begin
      num_errors++;
      results();
    end
  endtask

  task automatic t_interval();
    int n;
    wr(REF_H_ADDR, 8'h00);
    wr(REF_L_ADDR, 8'h02);
    pend(8'h00);
    wr(CTRL_ADDR, 8'h86);
    wait_flip(n);
    wait_flip(n);
    chk("match period", 16'h0003, n[15:0]);
    chk("match pend", 16'h0001, {15'h0, mc_p});
    chk("irq on", 16'h0001, {15'h0, irq});
    chk("mc vector", {8'h00, MC_VECTOR}, {8'h00, vec});
    wait_flip(n);
    chk("toggle again", 16'h0003, n[15:0]);
    wr(CTRL_ADDR, 8'he0);
    chk("irq masked", 16'h0000, {15'h0, irq});
    rd(CNT_L_ADDR, d0);
    repeat (20) @(negedge clk_in);
    rd(CNT_L_ADDR, d1);
    chk("stopped", {8'h00, d0}, {8'h00, d1});
    wr(CTRL_ADDR, 8'he6);
    rd(CNT_L_ADDR, d0);
    chk("cleared", 16'h0000, {8'h00, d0});
    rd(CTRL_ADDR, d0);
    chk("clr self", 16'h00e2, {8'h00, d0});
    serv(1'b0);
    chk("sw clear kept", 16'h0001, {15'h0, mc_p});
    pend(8'hdf);
    chk("sw clear", 16'h0000, {15'h0, mc_p});
  endtask

  // stopped counter reads 0; capture copies it on the chosen edge
  task automatic t_capture();
    for (int m = 1; m < 3; m++) begin
      wr(CTRL_ADDR, {3'b111, m[1:0], 3'b010});
      for (int s = 0; s < 2; s++) begin
        wr(REF_L_ADDR, 8'h55);
        cap_lvl <= ~cap_lvl;
        repeat (3) @(negedge clk_in);
        rd(REF_L_ADDR, d0);
        if ((m == 1) == cap_lvl) begin
          chk("captured", 16'h0000, {8'h00, d0});
          chk("cap pend", 16'h0001, {15'h0, mc_p});
          mask3 = 1'b1;
          serv(1'b0);
          chk("hw clear", 16'h0000, {15'h0, mc_p});
          mask3 = 1'b0;
        end else begin
          chk("wrong edge", 16'h0055, {8'h00, d0});
        end
      end
    end
  endtask

  // one full wrap: high exactly while reference exceeds count
  task automatic t_pwm();
    int hi;
    logic seen;
    hi = 0;
    seen = 1'b0;
    wr(REF_L_ADDR, 8'h10);
    wr(CTRL_ADDR, 8'h9d);
    // skip the clear cycle so the window holds each count once
    @(negedge clk_in);
    for (int i = 0; i < 65536; i++) begin
      @(negedge clk_in);
      if (out_pin === 1'b1) hi++;
      if (ovf_p === 1'b1) seen = 1'b1;
    end
    chk("pwm high", 16'h0010, hi[15:0]);
    chk("wrap ovf", 16'h0001, {15'h0, seen});
    chk("ovf vector", {8'h00, OVF_VECTOR}, {8'h00, vec});
    serv(1'b1);
    chk("ovf service", 16'h0000, {15'h0, ovf_p});
  endtask

  initial begin
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    t_reset();
    t_divide();
    t_ext();
    t_interval();
    t_capture();
    t_pwm();
    results();
  end
endmodule
`default_nettype wire
